/* File: src/file_test_pattern_gen_check.sv */
// pattern source and pattern checker for file transfer tests, plus the
// small word fifo between the source and the storage write fifo
// assumes storage fifos on the far side: read data one cycle after pop
`timescale 1ns/1ps

module word_fifo #(
    parameter int WIDTH = 512,
    parameter int DEPTH = 8
) (
    input  wire logic             clock_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr_r;
    logic [PW-1:0]    rd_ptr_r;
    logic [PW:0]      level_r;
    logic             push;
    logic             pop;

    assign in_ready_o  = (level_r != (PW+1)'(DEPTH));
    assign out_valid_o = (level_r != '0);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem[rd_ptr_r];

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            level_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == PW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == PW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                level_r <= level_r + 1'b1;
            end else if (pop && !push) begin
                level_r <= level_r - 1'b1;
            end
        end
    end
endmodule : word_fifo

// How it works
// - five patterns: incrementing, decrementing, LFSR, all zeros, all ones
// - counting and LFSR segments open with a 64-bit header
// - zero and one fills cover every bit, no header
// - header in dwords 0 and 1 comes from the segment address
// - segment address starts from first file and size, steps per segment
// - dwords 2 through 127 of a segment carry the pattern
// - incrementing dwords come from a word counter stepping once per word, above a 4-bit dword index
// - decrementing words are the inverse of the incrementing ones
// - LFSR follows x^31 + x^21 + x + 1
// - LFSR word split into four 128-bit lanes with distinct seeds
// - each lane yields four successive 32-bit LFSR values per cycle
// - lane seeds are block address mixed with inverted address bits
// - checker keeps its own configuration copy loaded by a strobe
// - checker runs an identical generator for expected data
// - busy falls when the received count reaches the end position
// - checker pops while busy whenever the read fifo is not empty
// - any mismatch sets the failure flag
// - source pushes whenever the small fifo holds a word and almost-full is low
// - end position from file count and size; ends on equality
// - 3-bit select: 000 inc, 001 dec, 010 zeros, 011 ones, 100 LFSR
module file_test_pattern_gen_check
    import file_test_pkg::*;
(
    input  wire logic                       clock_i,
    input  wire logic                       rst_i,
    input  wire file_test_pkg::test_cfg_t   gen_cfg_i,
    input  wire logic                       gen_cfg_load_i,
    input  wire logic                       write_pattern_start_i,
    input  wire logic                       write_fifo_almost_full_i,
    output logic                            write_fifo_push_o,
    output logic [file_test_pkg::WORD_W-1:0] write_fifo_data_o,
    output logic                            gen_busy_o,
    input  wire file_test_pkg::test_cfg_t   chk_cfg_i,
    input  wire logic                       chk_cfg_load_i,
    input  wire logic                       verify_start_i,
    input  wire logic                       read_fifo_empty_i,
    input  wire logic [file_test_pkg::WORD_W-1:0] read_fifo_data_i,
    output logic                            read_fifo_pop_o,
    output logic                            test_busy_flag_o,
    output logic                            verify_fail_o
);
    import file_test_pkg::*;

    function automatic logic [DWORD_W-1:0] lfsr_step(
        input logic [DWORD_W-1:0] v
    );
        lfsr_step = {v[DWORD_W-2:0], v[TAP_HI] ^ v[TAP_MID] ^ v[TAP_LO]};
    endfunction : lfsr_step

    test_cfg_t         cfg_in [2];
    logic              load   [2];
    logic              start  [2];
    logic              adv    [2];
    logic              busy   [2];
    logic [WORD_W-1:0] word   [2];
    logic              src_ready;
    logic              fifo_valid;
    logic              pop_d_r;
    logic [WORD_W-1:0] exp_r;
    logic              fail_r;

    assign cfg_in[0] = gen_cfg_i;
    assign cfg_in[1] = chk_cfg_i;
    assign load[0]   = gen_cfg_load_i;
    assign load[1]   = chk_cfg_load_i;
    // a start is taken on any cycle it is high; a longer pulse restarts
    assign start[0]  = write_pattern_start_i;
    assign start[1]  = verify_start_i;
    assign adv[0]    = busy[0] && src_ready;
    // busy already drops at the end position, so no pop past it
    assign adv[1]    = busy[1] && !read_fifo_empty_i;

    // channel 0 is the source, channel 1 the checker's reference
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        test_cfg_t              cfg_r;
        logic                   busy_r;
        logic [CNT_W-1:0]       cnt_r;
        logic [CNT_W-1:0]       end_r;
        logic [ADDR_W-1:0]      seg_r;
        logic [SEG_IDX_W-1:0]   widx_r;
        logic [DWORD_W-1:0]     lane_r   [LANES];
        logic [DWORD_W-1:0]     lane_nxt [LANES];
        logic [LANES*DWORD_W-1:0] lane_val [LANES];
        logic [5:0]             shift;

        assign busy[ch] = busy_r;
        assign shift    = 6'(cfg_r.file_size_code) + FILE_SIZE_CODE_BASE_LOG2;

        always_ff @(posedge clock_i or posedge rst_i) begin
            if (rst_i) begin
                cfg_r <= '{default: '0, pattern_select: PAT_INC};
            end else if (load[ch]) begin
                cfg_r <= cfg_in[ch];
            end
        end

        always_ff @(posedge clock_i or posedge rst_i) begin
            if (rst_i) begin
                busy_r <= 1'b0;
                cnt_r  <= '0;
                end_r  <= '0;
            end else if (start[ch]) begin
                cnt_r  <= '0;
                end_r  <= CNT_W'(cfg_r.file_count) << (shift + 6'd3);
                busy_r <= (cfg_r.file_count != '0);
            end else if (adv[ch]) begin
                cnt_r <= cnt_r + 1'b1;
                if (cnt_r + 1'b1 == end_r) begin
                    busy_r <= 1'b0;
                end
            end
        end

        always_ff @(posedge clock_i or posedge rst_i) begin
            if (rst_i) begin
                seg_r  <= '0;
                widx_r <= '0;
            end else if (start[ch]) begin
                seg_r  <= ADDR_W'(cfg_r.first_file_index) << shift;
                widx_r <= '0;
            end else if (adv[ch]) begin
                widx_r <= widx_r + 1'b1;
                if (widx_r == SEG_LAST) begin
                    seg_r <= seg_r + 1'b1;
                end
            end
        end

        for (genvar k = 0; k < LANES; k++) begin : g_lane
            logic [DWORD_W-1:0] v0;
            logic [DWORD_W-1:0] v1;
            logic [DWORD_W-1:0] v2;
            logic [DWORD_W-1:0] v3;
            // reseed at each segment start so segments stand alone
            assign v0 = (widx_r == '0)
                ? seg_r[DWORD_W-1:0] ^ LANE_INV[k*DWORD_W +: DWORD_W]
                : lane_r[k];
            assign v1 = lfsr_step(v0);
            assign v2 = lfsr_step(v1);
            assign v3 = lfsr_step(v2);
            assign lane_nxt[k] = lfsr_step(v3);
            assign lane_val[k] = {v3, v2, v1, v0};

            always_ff @(posedge clock_i or posedge rst_i) begin
                if (rst_i) begin
                    lane_r[k] <= '0;
                end else if (adv[ch]) begin
                    lane_r[k] <= lane_nxt[k];
                end
            end
        end

        always_comb begin
            logic [DWORD_W-1:0] inc;
            inc = '0;
            for (int j = 0; j < DWORDS; j++) begin
                inc = {cnt_r[DWORD_W-5:0], 4'(j)};
                unique case (cfg_r.pattern_select)
                    PAT_INC:  word[ch][j*DWORD_W +: DWORD_W] = inc;
                    PAT_DEC:  word[ch][j*DWORD_W +: DWORD_W] = ~inc;
                    PAT_ZERO: word[ch][j*DWORD_W +: DWORD_W] = '0;
                    PAT_ONE:  word[ch][j*DWORD_W +: DWORD_W] = '1;
                    PAT_LFSR: word[ch][j*DWORD_W +: DWORD_W] =
                        lane_val[j/LANES][(j%LANES)*DWORD_W +: DWORD_W];
                    default:  word[ch][j*DWORD_W +: DWORD_W] = inc;
                endcase
            end
            // header overrides dwords 0-1 of a segment; the rest is pattern
            if (widx_r == '0 && cfg_r.pattern_select != PAT_ZERO
                && cfg_r.pattern_select != PAT_ONE) begin
                word[ch][2*DWORD_W-1:0] = {HDR_PAD, seg_r};
            end
        end
    end

    // expected data comes from the same generator as the source
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pop_d_r <= 1'b0;
            exp_r   <= '0;
        end else begin
            pop_d_r <= adv[1];
            if (adv[1]) begin
                exp_r <= word[1];
            end
        end
    end

    // a mismatch in the start cycle still sets the flag
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            fail_r <= 1'b0;
        end else if (pop_d_r && read_fifo_data_i != exp_r) begin
            fail_r <= 1'b1;
        end else if (verify_start_i) begin
            fail_r <= 1'b0;
        end
    end

    // the small fifo absorbs the source while almost-full holds it off
    word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_src_fifo (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .in_valid_i  (busy[0]),
        .in_ready_o  (src_ready),
        .in_data_i   (word[0]),
        .out_valid_o (fifo_valid),
        .out_ready_i (!write_fifo_almost_full_i),
        .out_data_o  (write_fifo_data_o)
    );

    assign write_fifo_push_o = fifo_valid && !write_fifo_almost_full_i;
    assign gen_busy_o        = busy[0];
    assign read_fifo_pop_o   = adv[1];
    assign test_busy_flag_o  = busy[1];
    assign verify_fail_o     = fail_r;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    property p_push_gate;
        write_fifo_push_o |-> !write_fifo_almost_full_i && fifo_valid;
    endproperty
    a_push_gate: assert property (p_push_gate)
        else $error("push while almost full");

    property p_pop_avail;
        test_busy_flag_o && !read_fifo_empty_i |-> read_fifo_pop_o;
    endproperty
    a_pop_avail: assert property (p_pop_avail)
        else $error("data waiting but no pop");

    property p_pop_stop;
        read_fifo_pop_o |-> g_ch[1].cnt_r != g_ch[1].end_r;
    endproperty
    a_pop_stop: assert property (p_pop_stop)
        else $error("pop past end position");

    property p_busy_end;
        adv[1] && !verify_start_i && g_ch[1].cnt_r + 1'b1 == g_ch[1].end_r
            |=> !test_busy_flag_o ##1 !test_busy_flag_o;
    endproperty
    a_busy_end: assert property (p_busy_end)
        else $error("busy held past end position");

    property p_mismatch;
        pop_d_r && read_fifo_data_i != exp_r |=> verify_fail_o;
    endproperty
    a_mismatch: assert property (p_mismatch)
        else $error("mismatch not flagged");

    property p_fail_hold;
        verify_fail_o && !verify_start_i |=> verify_fail_o;
    endproperty
    a_fail_hold: assert property (p_fail_hold)
        else $error("failure flag dropped");

    property p_seg_step;
        adv[0] && !start[0] && g_ch[0].widx_r == SEG_LAST
            |=> g_ch[0].seg_r == $past(g_ch[0].seg_r) + 1'b1;
    endproperty
    a_seg_step: assert property (p_seg_step)
        else $error("segment address did not step");

    property p_header;
        busy[0] && g_ch[0].widx_r == '0
            && g_ch[0].cfg_r.pattern_select == PAT_INC
            |-> word[0][63:0] == {HDR_PAD, g_ch[0].seg_r};
    endproperty
    a_header: assert property (p_header)
        else $error("header not from segment address");

    property p_fill;
        busy[0] && g_ch[0].cfg_r.pattern_select == PAT_ONE
            |-> word[0] == '1;
    endproperty
    a_fill: assert property (p_fill)
        else $error("fill word not all ones");

    property p_inc_step;
        adv[0] && !start[0] && g_ch[0].cfg_r.pattern_select == PAT_INC
            && g_ch[0].widx_r != SEG_LAST
            |=> word[0][95:64] == $past(word[0][95:64]) + INC_STEP;
    endproperty
    a_inc_step: assert property (p_inc_step)
        else $error("incrementing pattern broken");
endmodule : file_test_pattern_gen_check

/* File: src/file_test_pkg.sv */
// constants, pattern codes and configuration carrier for the file test logic
// assumes one user clock; sizes in 512-bit words and 512-byte segments
package file_test_pkg;
    localparam int WORD_W     = 512;
    localparam int DWORD_W    = 32;
    localparam int DWORDS     = 16;
    localparam int LANES      = 4;
    localparam int SEG_IDX_W  = 3;
    localparam int ADDR_W     = 48;
    localparam int CNT_W      = 48;
    localparam int NAME_W     = 27;
    localparam int FILE_SIZE_CODE_W    = 4;
    localparam int FIFO_DEPTH = 8;
    localparam logic [SEG_IDX_W-1:0] SEG_LAST = 3'h7;
    // segments per file is two to the power (file_size_code + this)
    localparam logic [5:0] FILE_SIZE_CODE_BASE_LOG2 = 6'h0;
    // feedback taps of the x^31 + x^21 + x + 1 sequence
    localparam int TAP_HI  = 30;
    localparam int TAP_MID = 20;
    localparam int TAP_LO  = 0;
    // per-lane inversion masks that make the four lane seeds differ
    localparam logic [LANES*DWORD_W-1:0] LANE_INV =
        {32'h00ff_ffff, 32'hffff_0000, 32'h0000_00ff, 32'h0000_0000};
    localparam logic [15:0] HDR_PAD = 16'h0000;
    localparam logic [DWORD_W-1:0] INC_STEP = 32'h0000_0010;

    typedef enum logic [2:0] {
        PAT_INC  = 3'h0,
        PAT_DEC  = 3'h1,
        PAT_ZERO = 3'h2,
        PAT_ONE  = 3'h3,
        PAT_LFSR = 3'h4
    } pattern_t;

    typedef struct packed {
        logic [NAME_W-1:0]  file_count;
        logic [NAME_W-1:0]  first_file_index;
        logic [FILE_SIZE_CODE_W-1:0] file_size_code;
        pattern_t           pattern_select;
    } test_cfg_t;
endpackage : file_test_pkg

/* File: tb/far_fifo_model.sv */
// far side storage fifos: a write sink and a read source on one queue
// assumes read data is wanted one cycle after the pop edge
`timescale 1ns/1ps

module far_fifo_model
    import file_test_pkg::*;
(
    input  wire logic                              clock_i,
    input  wire logic                              rst_i,
    input  wire logic                              stall_i,
    input  wire logic                              corrupt_i,
    input  wire logic                              push_i,
    input  wire logic [file_test_pkg::WORD_W-1:0]  push_data_i,
    input  wire logic                              pop_i,
    output logic                                   almost_full_o,
    output logic                                   empty_o,
    output logic      [file_test_pkg::WORD_W-1:0]  pop_data_o,
    output int                                     bad_o
);
    import file_test_pkg::*;
    logic [WORD_W-1:0] q [$];

    assign almost_full_o = stall_i;

    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            empty_o <= 1'b1;
            bad_o <= 0;
            pop_data_o <= '0;
        end else begin
            if (push_i && almost_full_o)
                bad_o <= bad_o + 1;
            if (push_i)
                q.push_back(push_data_i);
            // idle bus toggles so a stale word never passes for data
            if (pop_i && q.size() > 0)
                pop_data_o <= q.pop_front() ^ WORD_W'(corrupt_i);
            else
                pop_data_o <= ~pop_data_o;
            empty_o <= (q.size() == 0);
        end
    end
endmodule : far_fifo_model

/* File: tb/file_test_pattern_gen_check_bench.sv */
// bench for the pattern source and checker, looped through a far fifo
// assumes the far fifo model returns words in push order
`timescale 1ns/1ps

module file_test_pattern_gen_check_bench;
    import file_test_pkg::*;
    logic              clock_i = 1'b0;
    logic              rst_i = 1'b1;
    test_cfg_t         gcfg = '0;
    test_cfg_t         ccfg = '0;
    logic              gload = 1'b0, gstart = 1'b0, cload = 1'b0;
    logic              vstart = 1'b0, stall = 1'b0, corrupt = 1'b0;
    logic              push, gbusy, pop, cbusy, fail, af, empty;
    logic [WORD_W-1:0] wdata, rdata, ew, wv;
    int                bad, pi, n;
    int                miscompares = 0;
    int                check_count = 0;

    initial forever #12.5 clock_i = ~clock_i;

    file_test_pattern_gen_check file_test_pattern_gen_check_i (
        .clock_i(clock_i), .rst_i(rst_i), .gen_cfg_i(gcfg),
        .gen_cfg_load_i(gload), .write_pattern_start_i(gstart),
        .write_fifo_almost_full_i(af), .write_fifo_push_o(push),
        .write_fifo_data_o(wdata), .gen_busy_o(gbusy),
        .chk_cfg_i(ccfg), .chk_cfg_load_i(cload),
        .verify_start_i(vstart), .read_fifo_empty_i(empty),
        .read_fifo_data_i(rdata), .read_fifo_pop_o(pop),
        .test_busy_flag_o(cbusy), .verify_fail_o(fail));

    far_fifo_model far_fifo_model_i (
        .clock_i(clock_i), .rst_i(rst_i), .stall_i(stall),
        .corrupt_i(corrupt), .push_i(push), .push_data_i(wdata),
        .pop_i(pop), .almost_full_o(af), .empty_o(empty),
        .pop_data_o(rdata), .bad_o(bad));

    task results;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results

    task check(string what, logic [WORD_W-1:0] seen, logic [WORD_W-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task tick(int c);
        repeat (c) @(negedge clock_i);
    endtask : tick

    // which 0: source done and all words landed; which 1: checker idle
    task wait_for(int which, int words);
        int i;
        for (i = 0; i < 3000; i++) begin
            tick(1);
            // stall the far fifo in bursts so the internal fifo fills
            stall = (which == 0) && (i % 7 < 3);
            if (which == 0 && gbusy === 1'b0
                && far_fifo_model_i.q.size() == words)
                return;
            if (which == 1 && cbusy === 1'b0)
                return;
        end
        miscompares++;
        $display("timeout waiting on run %0d", which);
        results();
    endtask : wait_for

    function automatic logic [31:0] lfsr(logic [31:0] v);
        return {v[30:0], v[30] ^ v[20] ^ v[0]};
    endfunction : lfsr

    function automatic logic [WORD_W-1:0] exp_word(pattern_t p, int n,
                                                   logic [47:0] a0);
        logic [WORD_W-1:0] w;
        logic [47:0]       a;
        logic [31:0]       v [LANES];
        logic [31:0]       nn;
        int                k, i, m;
        a = a0 + 48'(n / 8);
        nn = n;
        for (k = 0; k < LANES; k++)
            v[k] = a[31:0] ^ LANE_INV[32*k +: 32];
        for (m = n - n % 8; m <= n; m++) begin
            for (k = 0; k < LANES; k++) begin
                for (i = 0; i < 4; i++) begin
                    w[128*k + 32*i +: 32] = v[k];
                    v[k] = lfsr(v[k]);
                end
            end
        end
        if (p == PAT_INC || p == PAT_DEC)
            for (k = 0; k < DWORDS; k++)
                w[32*k +: 32] = {nn[27:0], 4'(k)};
        if (p == PAT_DEC)
            w = ~w;
        if (p == PAT_ZERO)
            w = '0;
        if (p == PAT_ONE)
            w = '1;
        if (n % 8 == 0 && p inside {PAT_INC, PAT_DEC, PAT_LFSR})
            w[63:0] = {HDR_PAD, a};
        return w;
    endfunction : exp_word

    task run_gen(pattern_t p, int fc, int fsc);
        gcfg = '{27'(fc), 27'd3, 4'(fsc), p};
        gload = 1'b1;
        tick(1);
        gload = 1'b0;
        gstart = 1'b1;
        tick(1);
        gstart = 1'b0;
        wait_for(0, fc << (fsc + 3));
        stall = 1'b0;
    endtask : run_gen

    task run_ver(pattern_t p, int fc, int fsc);
        ccfg = '{27'(fc), 27'd3, 4'(fsc), p};
        gcfg = '{27'd5, 27'd9, 4'd2, PAT_ONE};
        cload = 1'b1;
        gload = 1'b1;
        tick(1);
        cload = 1'b0;
        gload = 1'b0;
        vstart = 1'b1;
        tick(1);
        vstart = 1'b0;
        wait_for(1, 0);
        tick(3);
    endtask : run_ver

    task t_reset;
        check("outputs in reset",
              WORD_W'({push, gbusy, pop, cbusy, fail}), '0);
        $display("test reset done");
    endtask : t_reset

    task t_patterns;
        for (pi = 0; pi < 5; pi++) begin
            far_fifo_model_i.q.delete();
            run_gen(pattern_t'(pi), 1, 1);
            for (n = 0; n < 16; n++) begin
                ew = exp_word(pattern_t'(pi), n, 48'd6);
                wv = far_fifo_model_i.q[n];
                check("pushed word", wv, ew);
                check("seg head", wv[127:0], ew[127:0]);
                check("lanes", wv[511:128], ew[511:128]);
            end
            check("push while almost full", bad, 0);
            run_ver(pattern_t'(pi), 1, 1);
            check("fail flag", fail, 0);
            check("words left", far_fifo_model_i.q.size(), 0);
        end
        $display("test patterns done");
    endtask : t_patterns

    task t_fail;
        far_fifo_model_i.q.delete();
        run_gen(PAT_INC, 2, 0);
        corrupt = 1'b1;
        run_ver(PAT_INC, 1, 0);
        check("fail on bad word", fail, 1);
        check("words left at end", far_fifo_model_i.q.size(), 8);
        corrupt = 1'b0;
        tick(4);
        check("fail held", fail, 1);
        vstart = 1'b1;
        tick(1);
        vstart = 1'b0;
        check("fail cleared by start", fail, 0);
        wait_for(1, 0);
        check("second run drained", far_fifo_model_i.q.size(), 0);
        $display("test fail done");
    endtask : t_fail

    initial begin
        tick(4);
        t_reset();
        rst_i = 1'b0;
        tick(1);
        t_patterns();
        t_fail();
        results();
    end
endmodule : file_test_pattern_gen_check_bench
